// ==== rtl/tpc_pkg.sv ====
// Constants, field layouts and timing counts of the transmit per-channel controller.
// Assumes a 40 MHz clk_i and an 8-bit register port on the same clock.
//
// What this block does
// - Access-mode bit must be set by software; reset clears it, disabling indirect access.
// - Enable bit 1 forwards per-channel bytes to the framer; 0 disables PCM processing and insertion, but signalling-source selection still applies.
// - Busy flag is 1 during an indirect access, drops on a clock edge after completion.
// - An indirect access completes within 640 ns of its start.
// - Writing address/control starts one access; 7-bit address and direction pick the target.
// - Direction bit 7 set requests a read, clear requests a write.
// - For a read, within 640 ns the data buffer holds the addressed byte.
// - PCM control at 01H-18H, idle code 19H-30H, signalling control 31H-48H.
// - Full-inversion bit inverts every bit of the channel's backplane PCM byte.
// - Sign inversion flips only the MSB; with full inversion, all bits but the MSB.
// - Idle-substitute bit replaces the channel byte with its programmed idle code.
// - Milliwatt bit replaces the channel byte with the digital milliwatt pattern.
// - Milliwatt beats idle code, idle code beats every inversion.
// - Inversion and substitutions behave the same for every framing format.
// - Zero-suppression select 00 disables zero code suppression for the channel.
// - Select 01 forces bit 8; in signalling frames with signalling bit 0, bit 7.
// - Select 10 replaces a suppressed byte with the pattern 10011000.
// - Select 11 forces bit 7 of a suppressed byte in every frame.
// - Idle code byte is sent most significant bit first.
// - Signalling-source bit picks stored A-D bits when 1, backplane signalling when 0.
// - Signalling-insert bit with a robbed-bit format enables signalling insertion.

package tpc_pkg;

   // ****************************************
   // Register offsets on the 8-bit port
   // ****************************************
   localparam logic [7:0] TPC_OFS_CONFIG      = 8'h30;
   localparam logic [7:0] TPC_OFS_STATUS      = 8'h31;
   localparam logic [7:0] TPC_OFS_ADDR_CTRL   = 8'h32;
   localparam logic [7:0] TPC_OFS_DATA        = 8'h33;

   // ****************************************
   // Register fields and reset values
   // ****************************************
   localparam int         TPC_CFG_PCEN_BIT    = 0;
   localparam int         TPC_CFG_IAM_BIT     = 1;
   localparam int         TPC_STAT_BUSY_BIT   = 7;
   localparam int         TPC_AC_DIR_BIT      = 7;
   localparam logic [7:0] TPC_ADDR_CTRL_RST   = 8'h00;
   localparam logic [7:0] TPC_DATA_RST        = 8'h00;
   localparam logic [7:0] TPC_INT_RST         = 8'h00;

   // ****************************************
   // Internal address map
   // ****************************************
   localparam int         TPC_NCHAN           = 24;
   localparam logic [6:0] TPC_IA_PCM_BASE     = 7'h01;
   localparam logic [6:0] TPC_IA_IDLE_BASE    = 7'h19;
   localparam logic [6:0] TPC_IA_SIG_BASE     = 7'h31;
   localparam logic [6:0] TPC_IA_LAST         = 7'h48;

   // ****************************************
   // Per-channel byte fields
   // ****************************************
   localparam int         TPC_PCM_INV_BIT     = 7;
   localparam int         TPC_PCM_IDLE_BIT    = 6;
   localparam int         TPC_PCM_MWS_BIT     = 5;
   localparam int         TPC_PCM_SINV_BIT    = 4;
   localparam int         TPC_PCM_ZSS0_BIT    = 1;
   localparam int         TPC_PCM_ZSS1_BIT    = 0;
   localparam int         TPC_SIG_SRC_BIT     = 7;
   localparam int         TPC_SIG_INS_BIT     = 6;

   localparam logic [1:0] TPC_ZSS_NONE        = 2'h0;
   localparam logic [1:0] TPC_ZSS_JAM8        = 2'h1;
   localparam logic [1:0] TPC_ZSS_DDS         = 2'h2;
   localparam logic [1:0] TPC_ZSS_JAM7        = 2'h3;
   localparam logic [7:0] TPC_DDS_PATTERN     = 8'h98;

   // Digital milliwatt sequence, one byte per frame
   localparam logic [63:0] TPC_MWS_SEQ        = 64'h1E0B0B1E9E8B8B9E;

   // ****************************************
   // Timing
   // ****************************************
   localparam int         TPC_CLK_PERIOD_NS   = 25;
   localparam int         TPC_ACCESS_NS       = 640;
   localparam int         TPC_ACCESS_CYC      = TPC_ACCESS_NS / TPC_CLK_PERIOD_NS;

   typedef enum logic {TPC_ACC_IDLE, TPC_ACC_RUN} tpc_acc_e;

endpackage : tpc_pkg

// ==== rtl/tpc_fifo_if.sv ====
// Carrier between the controller and its output FIFO.
// Assumes both ends run on the controller's single clock.
`timescale 1ns/1ps
`default_nettype none

interface tpc_fifo_if #(
   parameter int WIDTH = 18
);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : tpc_fifo_if

`default_nettype wire

// ==== rtl/tpc_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and registered full/empty.
// Assumes a single clock; the fill side sees in_ready straight from a flop.
`timescale 1ns/1ps
`default_nettype none

module tpc_fifo
   import tpc_pkg::*;
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   tpc_fifo_if.fifo  port
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [CW-1:0]    cnt_r;
   logic [CW-1:0]    cnt_nxt;
   logic             room_r;
   logic             empty_r;
   wire              push = port.in_valid & room_r;
   wire              pop  = ~empty_r & port.out_ready;

   assign port.in_ready  = room_r;
   assign port.out_valid = ~empty_r;
   assign port.out_data  = mem_r[rp_r];

   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + CW'(1);
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - CW'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_r    <= '0;
         rp_r    <= '0;
         cnt_r   <= '0;
         room_r  <= 1'b1;
         empty_r <= 1'b1;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
         end
         cnt_r   <= cnt_nxt;
         room_r  <= (cnt_nxt != CW'(DEPTH));
         empty_r <= (cnt_nxt == '0);
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= port.in_data;
      end
   end

endmodule : tpc_fifo

`default_nettype wire

// ==== rtl/tpc_tx_perchan.sv ====
// Transmit per-channel controller: register port, indirect access to 72
// per-channel bytes, PCM processing and signalling selection ahead of the framer.
// Assumes backplane PCM and register strobes come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none

module tpc_tx_perchan
   import tpc_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Backplane transmit PCM, one channel byte per beat
   input  wire logic       pcm_valid_i,
   output logic            pcm_ready_o,
   input  wire logic [7:0] pcm_data_i,
   input  wire logic [4:0] pcm_chan_i,
   input  wire logic       sig_frame_i,
   input  wire logic       sig_bit_i,
   input  wire logic [3:0] bpsig_i,
   input  wire logic       robbed_fmt_i,
   // Toward the basic transmit framer
   output logic            fr_valid_o,
   input  wire logic       fr_ready_i,
   output logic      [7:0] fr_data_o,
   output logic      [4:0] fr_chan_o,
   output logic      [3:0] fr_sig_o,
   output logic            fr_sig_ins_o
);
   localparam int NBYTES = 3 * TPC_NCHAN;
   localparam int WORD_W = 18;

   // ****************************************
   // Register port
   // ****************************************
   logic       access_mode_r;
   logic       perchan_en_r;
   logic [7:0] addr_ctrl_r;
   logic [7:0] data_buf_r;
   logic [7:0] rdata_r;
   logic       busy_r;

   wire  wr_cfg   = reg_wr_i & (reg_addr_i == TPC_OFS_CONFIG);
   wire  wr_ac    = reg_wr_i & (reg_addr_i == TPC_OFS_ADDR_CTRL);
   wire  wr_data  = reg_wr_i & (reg_addr_i == TPC_OFS_DATA);

   logic [7:0] rd_mux;
   always_comb begin
      unique case (reg_addr_i)
         TPC_OFS_CONFIG:    rd_mux = {6'h00, access_mode_r, perchan_en_r};
         TPC_OFS_STATUS:    rd_mux = {busy_r, 7'h00};
         TPC_OFS_ADDR_CTRL: rd_mux = addr_ctrl_r;
         TPC_OFS_DATA:      rd_mux = data_buf_r;
         default:           rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         access_mode_r <= 1'b0;
         perchan_en_r  <= 1'b0;
         rdata_r       <= 8'h00;
      end else begin
         if (wr_cfg) begin
            access_mode_r <= reg_wdata_i[TPC_CFG_IAM_BIT];
            perchan_en_r  <= reg_wdata_i[TPC_CFG_PCEN_BIT];
         end
         if (reg_rd_i) begin
            rdata_r <= rd_mux;
         end
      end
   end
   assign reg_rdata_o = rdata_r;

   // ****************************************
   // Indirect access engine
   // ****************************************
   tpc_acc_e   acc_r;
   logic [4:0] acc_cnt_r;
   logic [7:0] bytes_r [NBYTES];

   wire [6:0] ia_addr    = addr_ctrl_r[6:0];
   wire       ia_read    = addr_ctrl_r[TPC_AC_DIR_BIT];
   wire [6:0] ia_index   = ia_addr - TPC_IA_PCM_BASE;
   wire       ia_valid_w = (reg_wdata_i[6:0] >= TPC_IA_PCM_BASE) &&
                           (reg_wdata_i[6:0] <= TPC_IA_LAST);
   // A new request is taken only in indirect mode and with no access pending
   wire       start      = wr_ac & access_mode_r & ~busy_r & ia_valid_w;
   wire       acc_done   = (acc_r == TPC_ACC_RUN) &&
                           (acc_cnt_r == 5'(TPC_ACCESS_CYC - 1));

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_r       <= TPC_ACC_IDLE;
         acc_cnt_r   <= 5'h00;
         busy_r      <= 1'b0;
         addr_ctrl_r <= TPC_ADDR_CTRL_RST;
      end else begin
         if (wr_ac && !busy_r) begin
            addr_ctrl_r <= reg_wdata_i;
         end
         unique case (acc_r)
            TPC_ACC_IDLE: begin
               acc_cnt_r <= 5'h00;
               if (start) begin
                  acc_r  <= TPC_ACC_RUN;
                  busy_r <= 1'b1;
               end
            end
            TPC_ACC_RUN: begin
               acc_cnt_r <= acc_cnt_r + 5'h01;
               if (acc_done) begin
                  acc_r  <= TPC_ACC_IDLE;
                  busy_r <= 1'b0;
               end
            end
         endcase
      end
   end

   // Completed read loads the buffer; it wins over a software write in that cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_buf_r <= TPC_DATA_RST;
      end else if (acc_done && ia_read) begin
         data_buf_r <= bytes_r[ia_index];
      end else if (wr_data) begin
         data_buf_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < NBYTES; i++) begin
            bytes_r[i] <= TPC_INT_RST;
         end
      end else if (acc_done && !ia_read) begin
         bytes_r[ia_index] <= data_buf_r;
      end
   end

   // ****************************************
   // Per-channel PCM processing
   // ****************************************
   logic [2:0] mws_phase_r;
   wire        chan_ok  = (pcm_chan_i < 5'(TPC_NCHAN));
   wire [6:0]  ch_idx   = chan_ok ? {2'b00, pcm_chan_i} : 7'h00;
   wire [7:0]  pcm_ctl  = bytes_r[ch_idx];
   wire [7:0]  idle_cod = bytes_r[ch_idx + 7'(TPC_NCHAN)];
   wire [7:0]  sig_ctl  = bytes_r[ch_idx + 7'(2 * TPC_NCHAN)];
   wire        active   = perchan_en_r & chan_ok;

   wire        f_inv    = pcm_ctl[TPC_PCM_INV_BIT];
   wire        f_sinv   = pcm_ctl[TPC_PCM_SINV_BIT];
   wire        f_idle   = pcm_ctl[TPC_PCM_IDLE_BIT];
   wire        f_mws    = pcm_ctl[TPC_PCM_MWS_BIT];
   wire [1:0]  zss_sel  = {pcm_ctl[TPC_PCM_ZSS1_BIT], pcm_ctl[TPC_PCM_ZSS0_BIT]};

   // Inversion mask; MSB flips when exactly one of the two bits is set
   wire [7:0]  inv_mask = {f_inv ^ f_sinv, {7{f_inv}}};
   wire [7:0]  inv_data = pcm_data_i ^ inv_mask;
   wire [7:0]  mws_byte = TPC_MWS_SEQ[63 - 8 * mws_phase_r -: 8];
   // Byte leaves bit 7 first on the line, so the idle code keeps its order
   wire [7:0]  sub_data = f_mws  ? mws_byte :
                          f_idle ? idle_cod :
                                   inv_data;

   logic [7:0] zss_data;
   always_comb begin
      zss_data = sub_data;
      if (sub_data == 8'h00) begin
         unique case (zss_sel)
            TPC_ZSS_NONE: zss_data = sub_data;
            TPC_ZSS_JAM8: zss_data = (sig_frame_i && !sig_bit_i) ?
                                     8'h02 : 8'h01;
            TPC_ZSS_DDS:  zss_data = TPC_DDS_PATTERN;
            TPC_ZSS_JAM7: zss_data = 8'h02;
         endcase
      end
   end

   wire [7:0] out_byte = active ? zss_data : pcm_data_i;
   wire [3:0] sig_sel  = sig_ctl[TPC_SIG_SRC_BIT] ? sig_ctl[3:0] : bpsig_i;
   wire       sig_ins  = active & sig_ctl[TPC_SIG_INS_BIT] & robbed_fmt_i;

   // Milliwatt sequence steps once per frame, after the last channel
   wire       accept   = pcm_valid_i & pcm_ready_o;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mws_phase_r <= 3'h0;
      end else if (accept && pcm_chan_i == 5'(TPC_NCHAN - 1)) begin
         mws_phase_r <= mws_phase_r + 3'h1;
      end
   end

   // ****************************************
   // Output FIFO and registered framer stage
   // ****************************************
   tpc_fifo_if #(.WIDTH(WORD_W)) fq ();

   assign fq.in_valid  = pcm_valid_i;
   assign fq.in_data   = {sig_ins, sig_sel, pcm_chan_i, out_byte};
   assign pcm_ready_o  = fq.in_ready;
   assign fq.out_ready = ~fr_valid_o | fr_ready_i;

   tpc_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .port   (fq.fifo)
   );

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fr_valid_o   <= 1'b0;
         fr_data_o    <= 8'h00;
         fr_chan_o    <= 5'h00;
         fr_sig_o     <= 4'h0;
         fr_sig_ins_o <= 1'b0;
      end else if (fq.out_valid && fq.out_ready) begin
         fr_valid_o   <= 1'b1;
         fr_data_o    <= fq.out_data[7:0];
         fr_chan_o    <= fq.out_data[12:8];
         fr_sig_o     <= fq.out_data[16:13];
         fr_sig_ins_o <= fq.out_data[17];
      end else if (fr_ready_i) begin
         fr_valid_o   <= 1'b0;
      end
   end

endmodule : tpc_tx_perchan

`default_nettype wire

// ==== test/tpc_tx_perchan_props.sv ====
// Port checker for the transmit per-channel controller.
// Assumes it is bound into tpc_tx_perchan on its single clock.
`timescale 1ns/1ps
`default_nettype none

module tpc_tx_perchan_props
   import tpc_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       pcm_valid_i,
   input wire logic       pcm_ready_o,
   input wire logic       fr_valid_o,
   input wire logic       fr_ready_i,
   input wire logic [7:0] fr_data_o,
   input wire logic [4:0] fr_chan_o,
   input wire logic       fr_sig_ins_o
);
   // ****
   // Shadow of configuration, access timer and words in flight
   // ****
   logic [1:0] cfg_r;
   int         cnt_r;
   int         occ_r;
   wire        busy_w  = cnt_r != 0;
   wire        start_w = reg_wr_i && reg_addr_i == TPC_OFS_ADDR_CTRL && cfg_r[1] && !busy_w
                         && reg_wdata_i[6:0] >= TPC_IA_PCM_BASE && reg_wdata_i[6:0] <= TPC_IA_LAST;
   wire        take_w  = pcm_valid_i && pcm_ready_o;
   wire        give_w  = fr_valid_o && fr_ready_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_r <= 2'h0;
         cnt_r <= 0;
         occ_r <= 0;
      end else begin
         if (reg_wr_i && reg_addr_i == TPC_OFS_CONFIG) begin
            cfg_r <= reg_wdata_i[1:0];
         end
         cnt_r <= start_w ? TPC_ACCESS_CYC : (busy_w ? cnt_r - 1 : 0);
         occ_r <= occ_r + (take_w ? 1 : 0) - (give_w ? 1 : 0);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_cfg_wr;
      reg_wr_i && reg_addr_i == TPC_OFS_CONFIG;
   endsequence
   sequence s_cfg_rd;
      reg_rd_i && reg_addr_i == TPC_OFS_CONFIG;
   endsequence

   chk_busy_flag: assert property (reg_rd_i && reg_addr_i == TPC_OFS_STATUS
      |=> reg_rdata_o[7] == $past(busy_w)) else $error("busy flag wrong");
   chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < TPC_OFS_CONFIG
      || reg_addr_i > TPC_OFS_DATA) |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   chk_cfg_readback: assert property (s_cfg_wr ##2 s_cfg_rd
      |=> reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 3)) else $error("config readback wrong");
   chk_fr_hold: assert property (fr_valid_o && !fr_ready_i
      |=> fr_valid_o && $stable(fr_data_o) && $stable(fr_chan_o)) else $error("framer word dropped");
   chk_out_has_word: assert property (fr_valid_o |-> occ_r != 0)
      else $error("framer word without input");
   chk_ready_full: assert property (!pcm_ready_o |-> occ_r >= FIFO_DEPTH)
      else $error("input refused while room left");
   chk_ins_gate: assert property (fr_valid_o && fr_sig_ins_o |-> cfg_r[0])
      else $error("insertion while per-channel disabled");
endmodule : tpc_tx_perchan_props

bind tpc_tx_perchan tpc_tx_perchan_props #(.FIFO_DEPTH(FIFO_DEPTH)) tpc_tx_perchan_props_i (
   .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .pcm_valid_i(pcm_valid_i), .pcm_ready_o(pcm_ready_o), .fr_valid_o(fr_valid_o),
   .fr_ready_i(fr_ready_i), .fr_data_o(fr_data_o), .fr_chan_o(fr_chan_o),
   .fr_sig_ins_o(fr_sig_ins_o));

`default_nettype wire

// ==== test/tpc_framer_model.sv ====
// Behavioural basic transmit framer that collects processed words.
// Assumes the bench raises stall_i to hold words back.
`timescale 1ns/1ps
`default_nettype none

module tpc_framer_model (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        stall_i,
   input  wire logic        fr_valid_i,
   input  wire logic [17:0] word_i,
   output logic             fr_ready_o
);
   logic [17:0] got [$];

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fr_ready_o <= 1'b0;
      end else begin
         if (fr_valid_i && fr_ready_o) begin
            got.push_back(word_i);
         end
         fr_ready_o <= !stall_i;
      end
   end
endmodule : tpc_framer_model

`default_nettype wire

// ==== test/tpc_tx_perchan_tb.sv ====
// Self-checking bench for the transmit per-channel controller.
// Assumes the framer model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s exp=%h got=%h", n, e, g); end end

module tpc_tx_perchan_tb
   import tpc_pkg::*;
;
   localparam int DEPTH = 8;
   logic        clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, pcm_valid_i = 0;
   logic        sig_frame_i = 0, sig_bit_i = 0, robbed_fmt_i = 0, stall = 0, pcen = 0;
   logic        pcm_ready_o, fr_valid_o, fr_ready_i, fr_sig_ins_o;
   logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, pcm_data_i = 0, reg_rdata_o, fr_data_o;
   logic [4:0]  pcm_chan_i = 0, fr_chan_o;
   logic [3:0]  bpsig_i = 0, fr_sig_o;
   logic [7:0]  ctl [24] = '{default: 8'h00};
   logic [7:0]  idl [24] = '{default: 8'h00};
   logic [7:0]  sgc [24] = '{default: 8'h00};
   logic [17:0] exp_q [$];
   int          fail_count = 0, total_checks = 0, cyc = 0, mw = 0;

   tpc_tx_perchan #(.FIFO_DEPTH(DEPTH)) tpc_tx_perchan_i (.clk_i(clk_i), .rstn_i(rstn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pcm_valid_i(pcm_valid_i),
      .pcm_ready_o(pcm_ready_o), .pcm_data_i(pcm_data_i), .pcm_chan_i(pcm_chan_i),
      .sig_frame_i(sig_frame_i), .sig_bit_i(sig_bit_i), .bpsig_i(bpsig_i),
      .robbed_fmt_i(robbed_fmt_i), .fr_valid_o(fr_valid_o), .fr_ready_i(fr_ready_i),
      .fr_data_o(fr_data_o), .fr_chan_o(fr_chan_o), .fr_sig_o(fr_sig_o),
      .fr_sig_ins_o(fr_sig_ins_o));
   tpc_framer_model tpc_framer_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .stall_i(stall),
      .fr_valid_i(fr_valid_o), .word_i({fr_sig_ins_o, fr_sig_o, fr_chan_o, fr_data_o}),
      .fr_ready_o(fr_ready_i));

   // ****
   // Reference word for one channel byte
   // ****
   function automatic logic [17:0] ref_word(logic [4:0] c, logic [7:0] d, logic sf, logic sb,
                                            logic [3:0] bs, logic rb);
      logic [7:0] k;
      logic [7:0] v;
      k = ctl[c];
      v = d ^ {k[7] ^ k[4], {7{k[7]}}};
      if (k[6]) v = idl[c];
      if (k[5]) v = TPC_MWS_SEQ[63 - 8 * mw -: 8];
      if (v == 8'h00) begin
         case ({k[0], k[1]})
            2'h1: v = (sf && !sb) ? 8'h02 : 8'h01;
            2'h2: v = 8'h98;
            2'h3: v = 8'h02;
            default: v = 8'h00;
         endcase
      end
      if (!pcen) v = d;
      return {pcen && sgc[c][6] && rb, sgc[c][7] ? sgc[c][3:0] : bs, c, v};
   endfunction : ref_word

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask : rd

   task automatic indirect_access_mode(logic dir, logic [6:0] a, logic [7:0] d, output logic [7:0] q);
      logic [7:0] s;
      int n;
      if (!dir) wr(TPC_OFS_DATA, d);
      wr(TPC_OFS_ADDR_CTRL, {dir, a});
      rd(TPC_OFS_STATUS, s);
      `CHK("busy set", 1'b1, s[7])
      n = 0;
      while (s[7] === 1'b1 && n < 20) begin
         rd(TPC_OFS_STATUS, s);
         n++;
      end
      `CHK("access time", 1'b1, n <= 12)
      if (dir) rd(TPC_OFS_DATA, q);
   endtask : indirect_access_mode

   task automatic put(logic [6:0] a, logic [7:0] d);
      logic [7:0] q;
      indirect_access_mode(1'b0, a, d, q);
      if (a <= 7'h18) ctl[a - 7'h01] = d;
      else if (a <= 7'h30) idl[a - 7'h19] = d;
      else sgc[a - 7'h31] = d;
   endtask : put

   task automatic send(logic [4:0] c, logic [7:0] d, logic sf, logic sb, logic [3:0] bs, logic rb);
      pcm_valid_i <= 1'b1;
      pcm_chan_i <= c;
      pcm_data_i <= d;
      sig_frame_i <= sf;
      sig_bit_i <= sb;
      bpsig_i <= bs;
      robbed_fmt_i <= rb;
      exp_q.push_back(ref_word(c, d, sf, sb, bs, rb));
      if (c == 5'd23) mw = (mw + 1) % 8;
      do @(posedge clk_i); while (pcm_ready_o !== 1'b1);
   endtask : send

   task automatic drain();
      logic [17:0] e;
      logic [17:0] w;
      repeat (300) begin
         @(posedge clk_i);
         if (tpc_framer_model_i.got.size() >= exp_q.size()) break;
      end
      `CHK("word count", exp_q.size(), tpc_framer_model_i.got.size())
      while (exp_q.size() > 0 && tpc_framer_model_i.got.size() > 0) begin
         e = exp_q.pop_front();
         w = tpc_framer_model_i.got.pop_front();
         `CHK("framer word", e, w)
      end
      exp_q.delete();
   endtask : drain

   task automatic t_regs();
      logic [7:0] q;
      logic [7:0] bad [3] = '{8'h00, 8'h49, 8'h7F};
      rd(TPC_OFS_CONFIG, q);
      `CHK("config reset", 2'h0, q[1:0])
      rd(TPC_OFS_ADDR_CTRL, q);
      `CHK("addr reset", TPC_ADDR_CTRL_RST, q)
      rd(TPC_OFS_DATA, q);
      `CHK("data reset", TPC_DATA_RST, q)
      rd(8'h37, q);
      `CHK("unmapped read", 8'h00, q)
      wr(TPC_OFS_ADDR_CTRL, 8'h81);
      rd(TPC_OFS_STATUS, q);
      `CHK("no start with mode off", 1'b0, q[7])
      rd(TPC_OFS_ADDR_CTRL, q);
      `CHK("addr stored", 8'h81, q)
      wr(TPC_OFS_CONFIG, 8'h03);
      pcen = 1'b1;
      rd(TPC_OFS_CONFIG, q);
      `CHK("config readback", 2'h3, q[1:0])
      foreach (bad[i]) begin
         wr(TPC_OFS_ADDR_CTRL, bad[i]);
         rd(TPC_OFS_STATUS, q);
         `CHK("no start off map", 1'b0, q[7])
      end
   endtask : t_regs

   task automatic t_ind();
      logic [7:0] q;
      logic [6:0] at [6] = '{7'h01, 7'h18, 7'h19, 7'h30, 7'h31, 7'h48};
      foreach (at[i]) put(at[i], {1'b0, at[i]} ^ 8'hA5);
      foreach (at[i]) begin
         indirect_access_mode(1'b1, at[i], 8'h00, q);
         `CHK("indirect read", {1'b0, at[i]} ^ 8'hA5, q)
      end
      wr(TPC_OFS_DATA, 8'h3C);
      wr(TPC_OFS_ADDR_CTRL, 8'h19);
      wr(TPC_OFS_ADDR_CTRL, 8'h81);
      repeat (30) @(posedge clk_i);
      idl[0] = 8'h3C;
      rd(TPC_OFS_ADDR_CTRL, q);
      `CHK("write while busy", 8'h19, q)
      indirect_access_mode(1'b1, 7'h19, 8'h00, q);
      `CHK("busy write kept", 8'h3C, q)
   endtask : t_ind

   task automatic t_pcm();
      logic [23:0] tb [17] = '{24'h005A00, 24'h805A00, 24'h105A00, 24'h905A00, 24'h405A00,
         24'hD05A00, 24'h205A00, 24'h605A00, 24'h000000, 24'h020000, 24'h020002, 24'h020003,
         24'h010000, 24'h030000, 24'h82FF00, 24'h128000, 24'h413300};
      put(7'h1E, 8'hA7);
      put(7'h36, 8'hC6);
      foreach (tb[i]) begin
         put(7'h06, tb[i][23:16]);
         @(posedge clk_i);
         send(5'd5, tb[i][15:8], tb[i][1], tb[i][0], 4'h9, 1'b1);
         if (i == 6) send(5'd23, 8'h00, 1'b0, 1'b0, 4'h0, 1'b0);
         pcm_valid_i <= 1'b0;
      end
      drain();
   endtask : t_pcm

   task automatic t_sig();
      put(7'h36, 8'h00);
      put(7'h06, 8'h82);
      @(posedge clk_i);
      send(5'd5, 8'hFF, 1'b0, 1'b0, 4'hA, 1'b1);
      send(5'd5, 8'h00, 1'b1, 1'b1, 4'h5, 1'b1);
      pcm_valid_i <= 1'b0;
      put(7'h36, 8'h40);
      @(posedge clk_i);
      send(5'd5, 8'h11, 1'b0, 1'b0, 4'h3, 1'b0);
      send(5'd5, 8'h22, 1'b0, 1'b0, 4'h3, 1'b1);
      pcm_valid_i <= 1'b0;
      drain();
      wr(TPC_OFS_CONFIG, 8'h02);
      pcen = 1'b0;
      @(posedge clk_i);
      send(5'd5, 8'hFF, 1'b0, 1'b0, 4'h6, 1'b1);
      pcm_valid_i <= 1'b0;
      drain();
      wr(TPC_OFS_CONFIG, 8'h03);
      pcen = 1'b1;
   endtask : t_sig

   task automatic t_fill();
      int n;
      stall <= 1'b1;
      repeat (2) @(posedge clk_i);
      n = 0;
      repeat (20) begin
         pcm_valid_i <= 1'b1;
         pcm_chan_i <= n[4:0];
         pcm_data_i <= 8'h10 + n[7:0];
         @(posedge clk_i);
         if (pcm_ready_o === 1'b1) begin
            exp_q.push_back(ref_word(n[4:0], 8'h10 + n[7:0], sig_frame_i, sig_bit_i, bpsig_i,
                                     robbed_fmt_i));
            n++;
         end
      end
      `CHK("words held", DEPTH + 1, n)
      pcm_valid_i <= 1'b0;
      stall <= 1'b0;
      drain();
   endtask : t_fill

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_regs();
      t_ind();
      t_pcm();
      t_sig();
      t_fill();
      give_verdict();
   end
endmodule : tpc_tx_perchan_tb

`default_nettype wire
